// ---- rtl/bus_mastership.sv ----
// External bus mastership control with request, grant, busy, column strobe and bus clocks.
`timescale 1ns/1ns
module bus_mastership (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Core side requests and mode bits.
  input  wire logic ext_access_req_in,
  input  wire logic ext_cycle_busy_in,
  input  wire logic column_strobe_req_in,
  input  wire logic stop_wait_in,
  input  wire logic park_enable_in,
  input  wire logic request_hold_bit_in,
  input  wire logic mastership_enable_bit_in,
  input  wire logic address_tracing_enable_in,
  // Core side status.
  output logic      master_out,
  // Arbitration pins, active low.
  output logic      bus_request_n_out,
  input  wire logic bus_grant_n_in,
  input  wire logic bus_busy_line_n_in,
  output logic      bus_busy_line_n_out,
  output logic      bus_busy_line_oe_n_out,
  // Column strobe pin, active low.
  output logic      column_strobe_n_out,
  output logic      column_strobe_oe_n_out,
  // Clock pins.
  output logic      core_clock_out,
  output logic      bus_clock_out,
  output logic      bus_clock_oe_n_out,
  output logic      bus_clock_inv_out,
  output logic      bus_clock_inv_oe_n_out
);

  clk_phase_if phase ();

  logic [1:0] pins_sync;
  logic       grant;
  logic       busy;

  bus_arb_pkg::arb_state_t state;
  bus_arb_pkg::arb_state_t next_state;

  logic next_master;
  logic next_request_n;
  logic next_busy_n;
  logic next_busy_oe_n;
  logic next_cas_n;
  logic next_cas_oe_n;
  logic next_core_clock;
  logic next_bus_clock;
  logic next_bus_clock_oe_n;
  logic next_bus_clock_inv;
  logic next_bus_clock_inv_oe_n;
  logic want_request;

  core_clock_gen #(
    .DIV  (bus_arb_pkg::CORE_DIV),
    .LEAD (bus_arb_pkg::BUS_CLK_LEAD)
  ) u_clock_gen (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .phase  (phase)
  );

  // Grant and busy arrive from other chips and are filtered before use.
  pin_sync #(
    .W         (2),
    .RESET_VAL ({bus_arb_pkg::PIN_IDLE, bus_arb_pkg::PIN_IDLE})
  ) u_pin_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    ({bus_grant_n_in, bus_busy_line_n_in}),
    .value_out (pins_sync)
  );

  assign grant = !pins_sync[1]; // see R6
  assign busy  = !pins_sync[0];

  // Request follows only the external bus need and the hold bit.
  assign want_request = ext_access_req_in || request_hold_bit_in; // see R3 see R4 see R5

  always_comb
  begin
    next_state     = state;
    next_request_n = bus_request_n_out;
    // Pins move only at core output clock edges.
    if (phase.tick) // see R10
    begin
      if (stop_wait_in)
      begin
        if (!request_hold_bit_in)
        begin
          next_request_n = 1'h1; // see R2
        end
      end
      else
      begin
        next_request_n = !want_request; // see R3 see R4
      end
      case (state)
        bus_arb_pkg::ST_SLAVE:
        begin
          if (ext_access_req_in && grant)
          begin
            next_state = busy ? bus_arb_pkg::ST_PENDING : bus_arb_pkg::ST_MASTER; // see R7
          end
        end
        bus_arb_pkg::ST_PENDING:
        begin
          if (!grant)
          begin
            next_state = bus_arb_pkg::ST_SLAVE;
          end
          else if (!busy)
          begin
            next_state = bus_arb_pkg::ST_MASTER; // see R9
          end
        end
        bus_arb_pkg::ST_MASTER:
        begin
          if (!ext_cycle_busy_in)
          begin
            if (!grant)
            begin
              next_state = bus_arb_pkg::ST_RELEASE; // see R8
            end
            else if (!ext_access_req_in && !park_enable_in) // see R11
            begin
              next_state = bus_arb_pkg::ST_RELEASE;
            end
          end
          // Otherwise the bus stays parked for reuse.
        end
        bus_arb_pkg::ST_RELEASE:
        begin
          next_state = bus_arb_pkg::ST_SLAVE; // see R12
        end
        default:
        begin
          next_state = bus_arb_pkg::ST_SLAVE;
        end
      endcase
    end
    if (rst_in)
    begin
      next_state     = bus_arb_pkg::ST_SLAVE; // see R1
      next_request_n = 1'h1; // see R1
    end
  end

  always_comb
  begin
    next_master    = (next_state == bus_arb_pkg::ST_MASTER);
    // Busy is held low while master, driven high on release, and floats otherwise.
    next_busy_n    = !next_master; // see R9 see R11 see R12
    next_busy_oe_n = !(next_master || next_state == bus_arb_pkg::ST_RELEASE); // see R17
    // Column strobe.
    next_cas_n     = !(next_master && column_strobe_req_in);
    next_cas_oe_n  = !next_master && !mastership_enable_bit_in; // see R13
    // Clocks keep their quarter lead because both pass one register here.
    next_core_clock         = phase.core_level;
    next_bus_clock          = phase.bus_level; // see R15
    next_bus_clock_oe_n     = !(next_master && address_tracing_enable_in); // see R14
    next_bus_clock_inv      = !phase.bus_level; // see R16
    next_bus_clock_inv_oe_n = !next_master; // see R16
    if (rst_in)
    begin
      next_master             = 1'h0;
      next_busy_n             = 1'h1;
      next_busy_oe_n          = 1'h1;
      next_cas_n              = 1'h1;
      next_cas_oe_n           = 1'h1;
      next_core_clock         = 1'h0;
      next_bus_clock          = 1'h0;
      next_bus_clock_oe_n     = 1'h1;
      next_bus_clock_inv      = 1'h1;
      next_bus_clock_inv_oe_n = 1'h1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    state                  <= next_state;
    bus_request_n_out      <= next_request_n;
    master_out             <= next_master;
    bus_busy_line_n_out    <= next_busy_n;
    bus_busy_line_oe_n_out <= next_busy_oe_n;
    column_strobe_n_out    <= next_cas_n;
    column_strobe_oe_n_out <= next_cas_oe_n;
    core_clock_out         <= next_core_clock;
    bus_clock_out          <= next_bus_clock;
    bus_clock_oe_n_out     <= next_bus_clock_oe_n;
    bus_clock_inv_out      <= next_bus_clock_inv;
    bus_clock_inv_oe_n_out <= next_bus_clock_inv_oe_n;
  end

  chk_reset_to_slave : assert property (@(posedge clk_in) // see R1
    rst_in |=> bus_request_n_out && state == bus_arb_pkg::ST_SLAVE)
    else $error("Reset left request asserted or state not slave.");

  chk_reset_floats_pins : assert property (@(posedge clk_in) // see R1 see R17
    rst_in |=> bus_busy_line_oe_n_out && column_strobe_oe_n_out
    && bus_clock_oe_n_out && bus_clock_inv_oe_n_out)
    else $error("A pin was driven straight after reset.");

  chk_stop_drops_request : assert property (@(posedge clk_in) disable iff (rst_in) // see R2
    phase.tick && stop_wait_in && !request_hold_bit_in |=> bus_request_n_out)
    else $error("Request not dropped in stop or wait without hold.");

  chk_stop_holds_request : assert property (@(posedge clk_in) disable iff (rst_in) // see R2
    phase.tick && stop_wait_in && request_hold_bit_in ##1 !rst_in
    |-> $stable(bus_request_n_out))
    else $error("Request changed in stop or wait with hold set.");

  chk_request_follows_need : assert property (@(posedge clk_in) disable iff (rst_in) // see R3
    phase.tick && !stop_wait_in |=> bus_request_n_out == !$past(want_request))
    else $error("Request does not follow the external need and hold bit.");

  chk_hold_keeps_request : assert property (@(posedge clk_in) disable iff (rst_in) // see R4
    phase.tick && !stop_wait_in && request_hold_bit_in |=> !bus_request_n_out)
    else $error("Request not held asserted while the hold bit is set.");

  chk_request_on_tick : assert property (@(posedge clk_in) disable iff (rst_in) // see R10
    !phase.tick ##1 !rst_in |-> $stable(bus_request_n_out))
    else $error("Request changed away from a core clock edge.");

  chk_master_on_tick : assert property (@(posedge clk_in) disable iff (rst_in) // see R10
    !phase.tick ##1 !rst_in |-> $stable(master_out))
    else $error("Mastership changed away from a core clock edge.");

  chk_busy_on_tick : assert property (@(posedge clk_in) disable iff (rst_in) // see R10
    !phase.tick ##1 !rst_in
    |-> $stable(bus_busy_line_n_out) && $stable(bus_busy_line_oe_n_out))
    else $error("Busy drive changed away from a core clock edge.");

  chk_master_after_idle : assert property (@(posedge clk_in) disable iff (rst_in) // see R7
    $rose(master_out) |-> $past(grant) && !$past(busy))
    else $error("Mastership taken without grant or while busy.");

  chk_slave_goes_pending : assert property (@(posedge clk_in) disable iff (rst_in) // see R7
    phase.tick && state == bus_arb_pkg::ST_SLAVE && ext_access_req_in && grant && busy
    |=> state == bus_arb_pkg::ST_PENDING)
    else $error("Grant with busy asserted did not leave the master pending.");

  chk_pending_waits_busy : assert property (@(posedge clk_in) disable iff (rst_in) // see R7
    phase.tick && state == bus_arb_pkg::ST_PENDING && grant && busy
    |=> state == bus_arb_pkg::ST_PENDING)
    else $error("Pending master moved on while busy was asserted.");

  chk_pending_grant_loss : assert property (@(posedge clk_in) disable iff (rst_in) // see R7
    phase.tick && state == bus_arb_pkg::ST_PENDING && !grant
    |=> state == bus_arb_pkg::ST_SLAVE)
    else $error("Pending master kept waiting after grant was withdrawn.");

  chk_pending_to_master : assert property (@(posedge clk_in) disable iff (rst_in) // see R9
    phase.tick && state == bus_arb_pkg::ST_PENDING && grant && !busy |=> master_out)
    else $error("Pending master did not take the bus after busy fell.");

  chk_cycle_keeps_master : assert property (@(posedge clk_in) disable iff (rst_in) // see R8
    state == bus_arb_pkg::ST_MASTER && ext_cycle_busy_in |=> state == bus_arb_pkg::ST_MASTER)
    else $error("Mastership ended inside an external bus cycle.");

  chk_grant_loss_release : assert property (@(posedge clk_in) disable iff (rst_in) // see R8
    phase.tick && state == bus_arb_pkg::ST_MASTER && !grant && !ext_cycle_busy_in
    |=> state == bus_arb_pkg::ST_RELEASE ##[1:4] state == bus_arb_pkg::ST_SLAVE)
    else $error("Grant loss did not end mastership after the cycle.");

  chk_parked_stays : assert property (@(posedge clk_in) disable iff (rst_in) // see R11
    phase.tick && state == bus_arb_pkg::ST_MASTER && grant && park_enable_in
    |=> state == bus_arb_pkg::ST_MASTER)
    else $error("Parked master gave up the bus while still granted.");

  chk_release_drives_high : assert property (@(posedge clk_in) disable iff (rst_in) // see R12
    state == bus_arb_pkg::ST_RELEASE |-> bus_busy_line_n_out && !bus_busy_line_oe_n_out)
    else $error("Release does not drive busy high.");

  chk_release_one_tick : assert property (@(posedge clk_in) disable iff (rst_in) // see R12
    phase.tick && state == bus_arb_pkg::ST_RELEASE
    |=> state == bus_arb_pkg::ST_SLAVE && bus_busy_line_oe_n_out)
    else $error("Busy was not let go after one core clock period of release.");

  chk_master_claims_busy : assert property (@(posedge clk_in) disable iff (rst_in) // see R9
    master_out |-> !bus_busy_line_n_out && !bus_busy_line_oe_n_out)
    else $error("Master does not hold busy asserted.");

  chk_slave_floats_busy : assert property (@(posedge clk_in) // see R17 see R16
    disable iff (rst_in) state inside {bus_arb_pkg::ST_SLAVE, bus_arb_pkg::ST_PENDING}
    |-> bus_busy_line_oe_n_out && bus_clock_inv_oe_n_out)
    else $error("Busy or inverted bus clock driven while not master.");

  chk_cas_float : assert property (@(posedge clk_in) disable iff (rst_in) // see R13
    !next_master && !mastership_enable_bit_in |=> column_strobe_oe_n_out)
    else $error("Column strobe driven while not master with enable bit clear.");

  chk_cas_master_drive : assert property (@(posedge clk_in) disable iff (rst_in) // see R13
    next_master |=> !column_strobe_oe_n_out)
    else $error("Column strobe not driven while master.");

  chk_cas_level : assert property (@(posedge clk_in) disable iff (rst_in) // see R13
    master_out |-> column_strobe_n_out == !$past(column_strobe_req_in))
    else $error("Column strobe level does not follow the core request.");

  chk_bus_clock_gate : assert property (@(posedge clk_in) disable iff (rst_in) // see R14
    !bus_clock_oe_n_out |-> master_out && $past(address_tracing_enable_in))
    else $error("Bus clock driven without mastership and tracing enabled.");

  chk_bus_clock_on : assert property (@(posedge clk_in) disable iff (rst_in) // see R14
    master_out && $past(address_tracing_enable_in) |-> !bus_clock_oe_n_out)
    else $error("Bus clock not driven while master with tracing enabled.");

  chk_bus_clock_copy : assert property (@(posedge clk_in) disable iff (rst_in) // see R15
    !rst_in |=> bus_clock_out == $past(phase.bus_level))
    else $error("Bus clock pin does not follow the leading phase.");

  chk_inv_master_drive : assert property (@(posedge clk_in) disable iff (rst_in) // see R16
    master_out |-> !bus_clock_inv_oe_n_out)
    else $error("Inverted bus clock not driven while master.");

  chk_inv_clock_copy : assert property (@(posedge clk_in) disable iff (rst_in) // see R16
    !rst_in |=> bus_clock_inv_out == !$past(phase.bus_level))
    else $error("Inverted bus clock pin does not follow the inverted phase.");

  chk_inv_complement : assert property (@(posedge clk_in) disable iff (rst_in) // see R16
    !bus_clock_inv_oe_n_out |-> bus_clock_inv_out != bus_clock_out)
    else $error("Inverted bus clock is not the complement.");

endmodule : bus_mastership

// ---- rtl/bus_arb_pkg.sv ----
// Constants, state types and the list of behaviours for the external bus mastership block.
// What this block does
// R1: Reset holds the bus request deasserted and returns arbitration to the slave state.
// R2: In Stop or Wait, request drops when the hold bit is clear, else keeps its state.
// R3: Request rises when the core needs the external bus and falls when it does not.
// R4: With the hold bit set, request stays asserted even with no external access pending.
// R5: Only external bus needs move the request; internal bus accesses never do.
// R6: The arbiter changes grant synchronously to the core output clock to name the next master.
// R7: After grant, mastership is taken only once bus busy is seen deasserted.
// R8: Losing grant ends mastership at the end of the current external bus cycle.
// R9: A pending master becomes master only after busy falls, then asserts busy itself.
// R10: Every party changes bus busy synchronously to the core output clock.
// R11: A master may keep busy asserted after its transfers end and reuse the bus.
// R12: Busy is released by driving it high briefly and then no longer driving it.
// R13: Master drives the column strobe; non-master with enable bit clear tri-states it.
// R14: Master drives the bus clock only with address tracing enabled; otherwise tri-stated.
// R15: An active bus clock leads the core output clock by a quarter period.
// R16: Master drives the inverted bus clock as its complement; otherwise tri-stated.
// R17: When slave or pending, the busy line is not driven and is only sampled.
package bus_arb_pkg;

  // Clock of the block in nanoseconds.
  localparam int CLK_PERIOD_NS = 4;

  // Clock edges in one period of the core output clock.
  localparam int CORE_DIV = 4;

  // The bus clock leads by a quarter of a core output clock period, in clock edges.
  localparam int BUS_CLK_LEAD = CORE_DIV / 4;

  // Core output clock periods for which busy is driven high on release.
  localparam int RELEASE_TICKS = 1;

  // Idle level of the active low pins.
  localparam logic PIN_IDLE = 1'h1;

  // Arbitration states.
  typedef enum logic [1:0] {
    ST_SLAVE,
    ST_PENDING,
    ST_MASTER,
    ST_RELEASE
  } arb_state_t;

endpackage : bus_arb_pkg

// ---- rtl/clk_phase_if.sv ----
// Interface that carries the core output clock phase from its generator to the arbiter.
`timescale 1ns/1ns
interface clk_phase_if;
  logic tick;
  logic core_level;
  logic bus_level;

  modport gen
  (
    output tick,
    output core_level,
    output bus_level
  );

  modport use_side
  (
    input tick,
    input core_level,
    input bus_level
  );
endinterface : clk_phase_if

// ---- rtl/pin_sync.sv ----
// Three flop synchroniser that accepts a change once the second and third flops agree.
`timescale 1ns/1ns
module pin_sync #(
  parameter int         W         = 1,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  // Clock and reset.
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Asynchronous pin and its filtered value.
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] value_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;
  logic [W-1:0] next_stage3;
  logic [W-1:0] next_value;

  // The first stage is read only by the second.
  always_comb
  begin
    next_stage1 = pin_in;
    next_stage2 = stage1;
    next_stage3 = stage2;
    next_value  = (stage2 == stage3) ? stage3 : value_out;
    if (rst_in)
    begin
      next_stage1 = RESET_VAL;
      next_stage2 = RESET_VAL;
      next_stage3 = RESET_VAL;
      next_value  = RESET_VAL;
    end
  end

  always_ff @(posedge clk_in)
  begin
    stage1    <= next_stage1;
    stage2    <= next_stage2;
    stage3    <= next_stage3;
    value_out <= next_value;
  end

endmodule : pin_sync

// ---- rtl/core_clock_gen.sv ----
// Divider that forms the core output clock phase and the leading bus clock phase.
`timescale 1ns/1ns
module core_clock_gen #(
  parameter int DIV  = bus_arb_pkg::CORE_DIV,
  parameter int LEAD = bus_arb_pkg::BUS_CLK_LEAD
) (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Phase outputs.
  clk_phase_if.gen  phase
);

  localparam int PW = $clog2(DIV);

  logic [PW-1:0] count;
  logic [PW-1:0] next_count;
  logic [PW-1:0] lead_count;
  logic          next_tick;
  logic          next_core;
  logic          next_bus;

  always_comb
  begin
    next_count = (count == PW'(DIV - 1)) ? '0 : count + PW'(1);
    lead_count = PW'((int'(next_count) + LEAD) % DIV);
    next_tick  = (next_count == '0);
    next_core  = (next_count < PW'(DIV / 2));
    next_bus   = (lead_count < PW'(DIV / 2)); // see R15
    if (rst_in)
    begin
      next_count = PW'(DIV - 1);
      next_tick  = 1'h0;
      next_core  = 1'h0;
      next_bus   = 1'h0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    count            <= next_count;
    phase.tick       <= next_tick;
    phase.core_level <= next_core;
    phase.bus_level  <= next_bus;
  end

  chk_bus_lead_quarter : assert property (@(posedge clk_in) disable iff (rst_in) // see R15
    $rose(phase.core_level) |-> phase.bus_level && !$past(phase.bus_level, 2))
    else $error("Bus clock phase does not lead the core clock by a quarter period.");

endmodule : core_clock_gen

// ---- tb/bus_party_model.sv ----
// Model of the external arbiter, a second bus master and the busy line pull-up.
`timescale 1ns/1ns
module bus_party_model (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Pins of the block.
  input  wire logic core_clock_in,
  input  wire logic bus_request_n_in,
  input  wire logic busy_n_in,
  input  wire logic busy_oe_n_in,
  // Scenario controls.
  input  wire logic grant_allow_in,
  input  wire logic other_claim_in,
  // Arbiter and wire outputs.
  output logic      bus_grant_n_out,
  output logic      busy_wire_out
);
  logic core_prev;
  logic other_drive_n;

  // Grant and the other master change only on a rising core output clock edge.
  always @(posedge clk_in)
  begin
    core_prev <= core_clock_in;
    if (rst_in)
    begin
      bus_grant_n_out <= 1'h1;
      other_drive_n   <= 1'h1;
    end
    else if (core_clock_in && !core_prev)
    begin
      bus_grant_n_out <= !(grant_allow_in && (!bus_request_n_in || !bus_grant_n_out));
      other_drive_n   <= !other_claim_in;
    end
  end

  // Driven levels win; with nobody driving the pull-up holds the line high.
  assign busy_wire_out = !busy_oe_n_in ? busy_n_in : (!other_drive_n ? 1'h0 : 1'h1);
endmodule : bus_party_model

// ---- tb/external_bus_mastership_control_bench.sv ----
// Self-checking bench of the external bus mastership block.
`timescale 1ns/1ns
module external_bus_mastership_control_bench;
  logic clk_in;
  logic rst_in;
  logic ext_req;
  logic cyc_busy;
  logic cas_req;
  logic stop_wait;
  logic park;
  logic hold;
  logic mbe;
  logic address_tracing_enable;
  logic grant_allow;
  logic other_claim;
  logic master;
  logic req_n;
  logic grant_n;
  logic wire_n;
  logic busy_n;
  logic busy_oe_n;
  logic cas_n;
  logic cas_oe_n;
  logic core_clk;
  logic bclk;
  logic bclk_oe_n;
  logic bclk_inv;
  logic bclk_inv_oe_n;
  int   error_cnt;
  int   compares;
  int   i;
  logic prev;

  bus_mastership bus_mastership_i (
    .clk_in(clk_in), .rst_in(rst_in), .ext_access_req_in(ext_req),
    .ext_cycle_busy_in(cyc_busy), .column_strobe_req_in(cas_req), .stop_wait_in(stop_wait),
    .park_enable_in(park), .request_hold_bit_in(hold), .mastership_enable_bit_in(mbe),
    .address_tracing_enable_in(address_tracing_enable), .master_out(master), .bus_request_n_out(req_n),
    .bus_grant_n_in(grant_n), .bus_busy_line_n_in(wire_n), .bus_busy_line_n_out(busy_n),
    .bus_busy_line_oe_n_out(busy_oe_n), .column_strobe_n_out(cas_n),
    .column_strobe_oe_n_out(cas_oe_n), .core_clock_out(core_clk), .bus_clock_out(bclk),
    .bus_clock_oe_n_out(bclk_oe_n), .bus_clock_inv_out(bclk_inv),
    .bus_clock_inv_oe_n_out(bclk_inv_oe_n)
  );

  bus_party_model bus_party_model_i (
    .clk_in(clk_in), .rst_in(rst_in), .core_clock_in(core_clk), .bus_request_n_in(req_n),
    .busy_n_in(busy_n), .busy_oe_n_in(busy_oe_n), .grant_allow_in(grant_allow),
    .other_claim_in(other_claim), .bus_grant_n_out(grant_n), .busy_wire_out(wire_n)
  );

  initial
  begin
    clk_in = 1'h0;
    forever #(bus_arb_pkg::CLK_PERIOD_NS / 2) clk_in = ~clk_in;
  end

  task step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step

  task check(input logic exp, input logic act);
    compares++;
    if (exp !== act)
    begin
      error_cnt++;
      $display("ERROR t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask : check

  task give_verdict;
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task s_reset;
    check(1'h1, req_n);
    check(1'h0, master);
    check(1'h1, busy_oe_n);
    check(1'h1, bclk_inv_oe_n);
    check(1'h1, cas_oe_n);
  endtask : s_reset

  task s_master;
    ext_req = 1'h1;
    grant_allow = 1'h1;
    cas_req = 1'h1;
    for (i = 0; i < 30 && master !== 1'h1; i++) step(1);
    check(1'h1, master);
    check(1'h0, req_n);
    check(1'h0, busy_oe_n);
    check(1'h0, busy_n);
    check(1'h0, bclk_inv_oe_n);
    check(1'h1, bclk_oe_n);
    step(5);
    check(1'h0, cas_oe_n);
    check(1'h0, cas_n);
    address_tracing_enable = 1'h1;
    step(6);
    check(1'h0, bclk_oe_n);
    for (i = 0; i < 8; i++)
    begin
      prev = bclk;
      check(~bclk, bclk_inv);
      step(1);
      check(prev, core_clk);
    end
  endtask : s_master

  task s_park_and_lose;
    park = 1'h1;
    ext_req = 1'h0;
    step(12);
    check(1'h1, req_n);
    check(1'h1, master);
    check(1'h0, wire_n);
    cyc_busy = 1'h1;
    grant_allow = 1'h0;
    step(24);
    check(1'h1, master);
    cyc_busy = 1'h0;
    mbe = 1'h0;
    for (i = 0; i < 20 && master !== 1'h0; i++) step(1);
    check(1'h0, master);
    check(1'h1, busy_n);
    check(1'h0, busy_oe_n);
    for (i = 0; i < 8 && busy_oe_n !== 1'h1; i++) step(1);
    check(1'h1, busy_oe_n);
    check(1'h1, wire_n);
    check(1'h1, cas_oe_n);
    check(1'h1, bclk_oe_n);
    check(1'h1, bclk_inv_oe_n);
  endtask : s_park_and_lose

  task s_hold_stop;
    hold = 1'h1;
    step(8);
    check(1'h0, req_n);
    stop_wait = 1'h1;
    step(12);
    check(1'h0, req_n);
    hold = 1'h0;
    ext_req = 1'h1;
    step(8);
    check(1'h1, req_n);
    stop_wait = 1'h0;
    step(8);
    check(1'h0, req_n);
    ext_req = 1'h0;
    step(8);
    check(1'h1, req_n);
    check(1'h0, master);
    cas_req = 1'h0;
    mbe = 1'h1;
    step(8);
    check(1'h1, req_n);
    check(1'h0, cas_oe_n);
    check(1'h1, cas_n);
  endtask : s_hold_stop

  task s_pending;
    other_claim = 1'h1;
    step(8);
    grant_allow = 1'h1;
    ext_req = 1'h1;
    step(30);
    check(1'h0, master);
    check(1'h1, busy_oe_n);
    other_claim = 1'h0;
    for (i = 0; i < 30 && master !== 1'h1; i++) step(1);
    check(1'h1, master);
    check(1'h0, wire_n);
    park = 1'h0;
    ext_req = 1'h0;
    for (i = 0; i < 30 && master !== 1'h0; i++) step(1);
    check(1'h0, master);
  endtask : s_pending

  initial
  begin
    error_cnt = 0;
    compares = 0;
    rst_in = 1'h1;
    {ext_req, cyc_busy, cas_req, stop_wait, park, hold} = 6'h00;
    {mbe, address_tracing_enable, grant_allow, other_claim} = 4'h0;
    step(3);
    rst_in = 1'h0;
    step(6);
    s_reset();
    s_master();
    s_park_and_lose();
    s_hold_stop();
    s_pending();
    give_verdict();
  end

  initial
  begin
    #20000;
    error_cnt++;
    give_verdict();
  end
endmodule : external_bus_mastership_control_bench
